/* File: logic/rpds_pkg.sv */
// Functional notes
// [RL1] seven outputs each own a 3-bit shutdown slot in register bits 2..0
// [RL2] reset loads each shutdown slot from that output's fused startup slot
// [RL3] trigger switches outputs off from highest slot downward, step by step
// [RL4] all shutdown slots zero: every output switches off at once
// [RL5] host rewrites shutdown slots only while the system is on
// [RL6] fused startup slots are inputs only; register writes never reach them
// [RL7] outputs sharing one nonzero slot switch off in the same step
//
// package of the regulator power-down sequencer: register map, field layout,
// output order and step timing. assumes an 8-bit register port.
package rpds_pkg;

  localparam int NUM_OUT = 7;
  localparam int SLOT_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // -----------------------------------------------------------------
  // output order in the enable vector
  // -----------------------------------------------------------------
  localparam int IDX_BUCK_OUT_A = 0;
  localparam int IDX_BUCK_OUT_B = 1;
  localparam int IDX_BUCK_OUT_C = 2;
  localparam int IDX_LINEAR_OUT_A = 3;
  localparam int IDX_LINEAR_OUT_B = 4;
  localparam int IDX_LINEAR_OUT_C = 5;
  localparam int IDX_MEMORY_REFERENCE_OUT = 6;

  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_BUCK1_SHUTDOWN_SLOT = 8'h5F;
  localparam logic [7:0] ADDR_BUCK2_SHUTDOWN_SLOT = 8'h60;
  localparam logic [7:0] ADDR_BUCK3_SHUTDOWN_SLOT = 8'h61;
  localparam logic [7:0] ADDR_LINEAR1_SHUTDOWN_SLOT = 8'h62;
  localparam logic [7:0] ADDR_LINEAR2_SHUTDOWN_SLOT = 8'h63;
  localparam logic [7:0] ADDR_LINEAR3_SHUTDOWN_SLOT = 8'h64;
  localparam logic [7:0] ADDR_MEMREF_SHUTDOWN_SLOT = 8'h65;
  localparam logic [7:0] ADDR_SEQ_CONTROL = 8'h66;
  localparam logic [7:0] ADDR_SEQ_STATUS = 8'h67;
  localparam logic [NUM_OUT-1:0][7:0] SLOT_ADDR = {
    ADDR_MEMREF_SHUTDOWN_SLOT, ADDR_LINEAR3_SHUTDOWN_SLOT, ADDR_LINEAR2_SHUTDOWN_SLOT,
    ADDR_LINEAR1_SHUTDOWN_SLOT, ADDR_BUCK3_SHUTDOWN_SLOT, ADDR_BUCK2_SHUTDOWN_SLOT,
    ADDR_BUCK1_SHUTDOWN_SLOT};

  // -----------------------------------------------------------------
  // field positions and reset values
  // -----------------------------------------------------------------
  localparam int SLOT_LSB = 0;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RESTORE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_SLOT_LSB = 2;
  localparam logic [NUM_OUT-1:0] ENABLE_RESET = 7'h7F;
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 3'h0;

  // -----------------------------------------------------------------
  // step timing
  // -----------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;
  localparam int STEP_TIME_US = 2;
  localparam int STEP_CYCLES = STEP_TIME_US * CLOCK_MHZ;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef logic [SLOT_W-1:0] rpds_slot_t;
  typedef logic [NUM_OUT-1:0][SLOT_W-1:0] rpds_slot_arr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rpds_bus_req_s;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_DROP,
    SEQ_WAIT,
    SEQ_DONE
  } rpds_state_e;

endpackage

/* File: logic/rpds_slot_scan.sv */
// highest shutdown slot among outputs still on, and which outputs hold it.
// assumes slots and live mask are stable registered values.
`timescale 1ns/10ps
module rpds_slot_scan
  import rpds_pkg::*;
(
  input wire rpds_slot_arr_t slots,
  input wire logic [NUM_OUT-1:0] live,
  output logic [SLOT_W-1:0] top_slot,
  output logic [NUM_OUT-1:0] top_mask,
  output logic any_live,
  output logic all_zero
);

  always_comb begin
    top_slot = SLOT_ZERO;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (live[i] && slots[i] > top_slot) begin
        top_slot = slots[i];
      end
    end
  end

  // equal slots share one step, slot zero goes last
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_mask
    assign top_mask[g] = live[g] && (slots[g] == top_slot); // [RL3] [RL7]
  end

  assign any_live = |live;
  assign all_zero = ~|slots; // [RL4]

endmodule

/* File: logic/rpds_sequencer.sv */
// regulator power-down sequencer: shutdown slot registers, register port
// and the stepping state machine that drops regulator enables.
// assumes synchronous inputs and an 8-bit strobed register port.
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module rpds_sequencer
  import rpds_pkg::*;
#(
  parameter int STEP_WAIT = STEP_CYCLES
)
(
  input wire logic clock,
  input wire logic reset,
  input wire rpds_bus_req_s bus_req,
  output logic [DATA_W-1:0] rdata,
  input wire rpds_slot_arr_t startup_slot_fuse,
  input wire logic system_on,
  input wire logic power_down_req,
  input wire logic power_restore_req,
  output logic [NUM_OUT-1:0] regulator_enable,
  output logic sequence_busy,
  output logic sequence_done
);

  // -----------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------
  if (STEP_WAIT < 1 || STEP_WAIT > 65535) begin : g_bad_wait
    $error("STEP_WAIT must lie in 1..65535");
  end
  // slot field and status layout must fit the 8-bit data path
  if (SLOT_LSB + SLOT_W > DATA_W) begin : g_bad_slot
    $error("slot field does not fit the data width");
  end
  if (STAT_SLOT_LSB + SLOT_W > DATA_W) begin : g_bad_stat
    $error("status slot field does not fit the data width");
  end
  if (NUM_OUT < 1 || SLOT_W < 1) begin : g_bad_outs
    $error("output count and slot width must be positive");
  end

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  rpds_slot_arr_t slot_q;
  rpds_slot_arr_t slot_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  rpds_state_e state_q;
  rpds_state_e state_d;
  logic [NUM_OUT-1:0] enable_q;
  logic [NUM_OUT-1:0] enable_d;
  logic [15:0] wait_q;
  logic [15:0] wait_d;
  logic [SLOT_W-1:0] cur_slot_q;
  logic [SLOT_W-1:0] cur_slot_d;
  logic [SLOT_W-1:0] top_slot;
  logic [NUM_OUT-1:0] top_mask;
  logic any_live;
  logic all_zero;
  logic ctrl_wr;
  logic sw_start;
  logic sw_restore;
  logic start;
  logic restore;

  // -----------------------------------------------------------------
  // slot scan
  // -----------------------------------------------------------------
  rpds_slot_scan u_scan (
    .slots(slot_q),
    .live(enable_q),
    .top_slot(top_slot),
    .top_mask(top_mask),
    .any_live(any_live),
    .all_zero(all_zero)
  );

  // -----------------------------------------------------------------
  // control decode
  // -----------------------------------------------------------------
  // one control write may carry both bits; only the state owning each acts
  assign ctrl_wr = bus_req.wr && (bus_req.addr == ADDR_SEQ_CONTROL);
  assign sw_start = ctrl_wr && bus_req.wdata[CTRL_START_BIT];
  assign sw_restore = ctrl_wr && bus_req.wdata[CTRL_RESTORE_BIT];
  assign start = power_down_req || sw_start;
  assign restore = power_restore_req || sw_restore;

  // -----------------------------------------------------------------
  // shutdown slot registers
  // -----------------------------------------------------------------
  // limitation: a slot raised above the step in progress is taken at the
  // next step, so strict descent holds only while the host stays out
  always_comb begin
    slot_d = slot_q;
    for (int i = 0; i < NUM_OUT; i++) begin
      // writes outside system-on are dropped, the order stays as it was
      if (bus_req.wr && system_on && bus_req.addr == SLOT_ADDR[i]) begin // [RL5]
        slot_d[i] = bus_req.wdata[SLOT_LSB +: SLOT_W]; // [RL1]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      // fuse values are only ever read, never written back
      slot_q <= startup_slot_fuse; // [RL2] [RL6]
    end else begin
      slot_q <= slot_d;
    end
  end

  // -----------------------------------------------------------------
  // register read port
  // -----------------------------------------------------------------
  // control is write-only and reads back zero, as do unmapped offsets
  // status shows the state at the strobe edge, not at the data cycle
  always_comb begin
    rdata_d = '0;
    if (bus_req.rd) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (bus_req.addr == SLOT_ADDR[i]) begin
          rdata_d[SLOT_LSB +: SLOT_W] = slot_q[i]; // [RL1]
        end
      end
      if (bus_req.addr == ADDR_SEQ_STATUS) begin
        rdata_d[STAT_BUSY_BIT] = sequence_busy;
        rdata_d[STAT_DONE_BIT] = sequence_done;
        rdata_d[STAT_SLOT_LSB +: SLOT_W] = cur_slot_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // -----------------------------------------------------------------
  // stepping state machine
  // -----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    enable_d = enable_q;
    wait_d = wait_q;
    cur_slot_d = cur_slot_q;
    case (state_q)
      SEQ_IDLE: begin
        if (start) begin
          if (all_zero) begin
            enable_d = '0; // [RL4]
            cur_slot_d = SLOT_ZERO;
            state_d = SEQ_DONE;
          end else begin
            state_d = SEQ_DROP;
          end
        end
      end
      SEQ_DROP: begin
        // every output holding the highest remaining slot goes off now
        enable_d = enable_q & ~top_mask; // [RL3] [RL7]
        cur_slot_d = top_slot;
        if ((enable_q & ~top_mask) == '0) begin
          state_d = SEQ_DONE;
        end else begin
          // drop cycle plus STEP_WAIT wait cycles space the groups
          wait_d = 16'(STEP_WAIT - 1);
          state_d = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (wait_q == '0) begin
          state_d = SEQ_DROP; // [RL3]
        end else begin
          wait_d = wait_q - 16'h0001;
        end
      end
      SEQ_DONE: begin
        // enables stay off until restore; further starts are ignored here
        if (restore) begin
          enable_d = ENABLE_RESET;
          cur_slot_d = SLOT_ZERO;
          state_d = SEQ_IDLE;
        end
      end
      default: begin
        state_d = SEQ_IDLE;
      end
    endcase
    // nothing left on: a stray start finishes at once
    if (state_q == SEQ_IDLE && start && !any_live) begin
      state_d = SEQ_DONE;
      enable_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= SEQ_IDLE;
      enable_q <= ENABLE_RESET;
      wait_q <= '0;
      cur_slot_q <= SLOT_ZERO;
    end else begin
      state_q <= state_d;
      enable_q <= enable_d;
      wait_q <= wait_d;
      cur_slot_q <= cur_slot_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // flags are decoded from the state register, so they never glitch apart
  assign regulator_enable = enable_q;
  assign sequence_busy = (state_q == SEQ_DROP) || (state_q == SEQ_WAIT);
  assign sequence_done = (state_q == SEQ_DONE);

endmodule

/* File: testbench/rpds_sequencer_asserts.sv */
// port checker for the power-down sequencer
// assumes a bind onto rpds_sequencer, one clock
`timescale 1ns/10ps
module rpds_sequencer_asserts
  import rpds_pkg::*;
#(
  parameter int STEP_WAIT = STEP_CYCLES
)
(
  input wire logic clock,
  input wire logic reset,
  input wire rpds_bus_req_s bus_req,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic power_down_req,
  input wire logic power_restore_req,
  input wire logic [NUM_OUT-1:0] regulator_enable,
  input wire logic sequence_busy,
  input wire logic sequence_done
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // ----
  // steps
  // ----
  sequence s_idle_start;
    power_down_req && !sequence_busy && !sequence_done;
  endsequence
  sequence s_hold_done;
    sequence_done && !power_restore_req && !bus_req.wr;
  endsequence
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_slot_upper: assert property ($past(bus_req.rd)
    && $past(bus_req.addr) == ADDR_BUCK3_SHUTDOWN_SLOT |-> rdata[7:3] == 5'h00)
    else $error("unused slot bits not zero");
  a_start_acts: assert property (s_idle_start |=> sequence_busy || sequence_done)
    else $error("start ignored in idle");
  a_done_off: assert property (sequence_done |-> regulator_enable == 7'h00)
    else $error("output on after shutdown");
  a_done_holds: assert property (s_hold_done |=> sequence_done)
    else $error("done lost without restore");
  a_never_rise: assert property (!$past(power_restore_req) && !$past(bus_req.wr)
    |-> (regulator_enable & ~$past(regulator_enable)) == 7'h00)
    else $error("output came on unasked");
  a_drop_in_seq: assert property (regulator_enable != $past(regulator_enable)
    && !$past(power_restore_req) && !$past(bus_req.wr) |-> sequence_busy || sequence_done)
    else $error("output dropped outside sequence");
endmodule

bind rpds_sequencer rpds_sequencer_asserts #(.STEP_WAIT(STEP_WAIT)) i_chk (
  .clock(clock), .reset(reset), .bus_req(bus_req), .rdata(rdata),
  .power_down_req(power_down_req), .power_restore_req(power_restore_req),
  .regulator_enable(regulator_enable), .sequence_busy(sequence_busy),
  .sequence_done(sequence_done));

/* File: testbench/tb_rpds_sequencer.sv */
// self-checking bench for the power-down sequencer
// assumes rpds_pkg and the checker compiled first
`timescale 1ns/10ps
module tb_rpds_sequencer
  import rpds_pkg::*;
;
  localparam int STEP = 3;
  localparam rpds_slot_arr_t FUSE = {3'h7, 3'h3, 3'h0, 3'h1, 3'h5, 3'h5, 3'h2};
  logic clock = 1'b0;
  logic reset = 1'b1;
  rpds_bus_req_s bus_req = '0;
  logic system_on = 1'b1;
  logic power_down_req = 1'b0;
  logic power_restore_req = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_OUT-1:0] regulator_enable;
  logic [NUM_OUT-1:0] exp_en;
  logic [NUM_OUT-1:0] m;
  logic sequence_busy;
  logic sequence_done;
  int err_count = 0;
  int checked = 0;
  int n;
  always #2.5 clock = ~clock;
  rpds_sequencer #(.STEP_WAIT(STEP)) i_dut (
    .clock(clock), .reset(reset), .bus_req(bus_req), .rdata(rdata),
    .startup_slot_fuse(FUSE), .system_on(system_on), .power_down_req(power_down_req),
    .power_restore_req(power_restore_req), .regulator_enable(regulator_enable),
    .sequence_busy(sequence_busy), .sequence_done(sequence_done));
  // ----
  // tasks
  // ----
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bad(input string s);
    err_count++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  task automatic chk_en(input logic [NUM_OUT-1:0] e);
    checked++;
    if (regulator_enable !== e) bad($sformatf("enable %h exp %h", regulator_enable, e));
  endtask
  task automatic chk_st(input logic b, input logic d);
    checked++;
    if ({sequence_busy, sequence_done} !== {b, d}) begin
      bad($sformatf("busy %b done %b exp %b %b", sequence_busy, sequence_done, b, d));
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clock);
    bus_req.wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    checked++;
    if (rdata !== e) bad($sformatf("read %h got %h exp %h", a, rdata, e));
    @(posedge clock);
  endtask
  // restore latency is one clock here, but poll with a bound
  task automatic wait_en(input logic [NUM_OUT-1:0] e);
    int k;
    k = 0;
    #1;
    while (regulator_enable !== e && k < 20) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk_en(e);
    if (k == 20) end_of_test();
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_slots();
    for (int i = 0; i < NUM_OUT; i++) rd(SLOT_ADDR[i], {5'h00, FUSE[i]});
  endtask
  // ----
  // tests
  // ----
  initial begin
    do_reset();
    rd_slots();
    wr(ADDR_BUCK3_SHUTDOWN_SLOT, 8'hFE);
    rd(ADDR_BUCK3_SHUTDOWN_SLOT, 8'h06);
    wr(ADDR_BUCK3_SHUTDOWN_SLOT, 8'hFD);
    rd(ADDR_BUCK3_SHUTDOWN_SLOT, 8'h05);
    system_on <= 1'b0;
    wr(ADDR_LINEAR1_SHUTDOWN_SLOT, 8'h07);
    system_on <= 1'b1;
    rd(ADDR_LINEAR1_SHUTDOWN_SLOT, 8'h01);
    rd(8'h70, 8'h00);
    $display("test registers done");
    power_down_req <= 1'b1;
    @(posedge clock);
    power_down_req <= 1'b0;
    exp_en = 7'h7F;
    n = 1;
    for (int s = 7; s >= 0; s--) begin
      m = '0;
      for (int i = 0; i < NUM_OUT; i++) m[i] = (FUSE[i] == s[2:0]);
      if (m != '0) begin
        repeat (n - 1) @(posedge clock);
        #1 chk_en(exp_en);
        exp_en = exp_en & ~m;
        @(posedge clock);
        #1 chk_en(exp_en);
        chk_st(exp_en != '0, exp_en == '0);
        n = STEP + 1;
      end
    end
    rd(ADDR_SEQ_STATUS, 8'h02);
    power_restore_req <= 1'b1;
    @(posedge clock);
    power_restore_req <= 1'b0;
    wait_en(7'h7F);
    chk_st(1'b0, 1'b0);
    $display("test stepped shutdown done");
    for (int i = 0; i < NUM_OUT; i++) wr(SLOT_ADDR[i], 8'h00);
    wr(ADDR_SEQ_CONTROL, 8'h01);
    #1 chk_en(7'h00);
    chk_st(1'b0, 1'b1);
    rd(ADDR_SEQ_STATUS, 8'h02);
    wr(ADDR_SEQ_CONTROL, 8'h02);
    wait_en(7'h7F);
    $display("test bypass done");
    do_reset();
    rd_slots();
    $display("test fuse reload done");
    end_of_test();
  end
endmodule
